// ### fetch_execute_timing.sv
/*
 Two-stage fetch/execute sequencer with branch flush and cycle clock out.
 Assumes program memory answers combinationally to prog_addr, and that the
 execute datapath reports branches with their target during phase four.
*/
`include "phase_timing_params.svh"
module fetch_execute_timing
   import phase_timing_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      master_clear_n,
   input  wire logic                      rc_mode,
   input  wire logic [`INSTR_WIDTH-1:0]   prog_data,
   input  wire logic                      branch_taken,
   input  wire logic [`PC_WIDTH-1:0]      branch_target,
   input  wire logic                      irq_enter,
   output logic      [`PC_WIDTH-1:0]      prog_addr,
   output logic      [`INSTR_WIDTH-1:0]   instr_word,
   output phase_strobe_t                  phase,
   output exec_strobe_t                   exec,
   output logic                           cycle_clock_out
);
   typedef struct packed {
      logic                      master_clear_n_meta;
      logic                      master_clear_n_sync;
      logic                      rc_meta;
      logic                      rc_sync;
      logic [`PC_WIDTH-1:0]      pc;
      logic [`PC_WIDTH-1:0]      fetch_pc;
      logic [`INSTR_WIDTH-1:0]   fetch_latch;
      logic                      fetch_ok;
      logic [`INSTR_WIDTH-1:0]   ir;
      logic                      ir_valid;
      logic                      clk_out;
   } seq_state_t;

   seq_state_t    state_reg;
   seq_state_t    state_next;
   phase_strobe_t ph;
   logic          cyc_clk;
   logic          hold;

   // RULE_12 reset held while clear low
   assign hold = ~state_reg.master_clear_n_sync;

   phase_gen u_phase_gen (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .hold      (hold),
      .strobe    (ph),
      .cycle_clk (cyc_clk)
   );

   // ==========================================
   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      // Pin synchronisers, only the second stages are read
      state_next.master_clear_n_meta = master_clear_n;
      state_next.master_clear_n_sync = state_reg.master_clear_n_meta;
      state_next.rc_meta   = rc_mode;
      state_next.rc_sync   = state_reg.rc_meta;
      // RULE_11 quarter-rate pin in RC mode
      state_next.clk_out   = state_reg.rc_sync & cyc_clk & ~hold;
      if (hold) begin
         // RULE_14 restart from address zero
         state_next.pc          = `RESET_VECTOR;
         state_next.fetch_pc    = `RESET_VECTOR;
         // RULE_15 pipeline empty
         state_next.fetch_ok    = 1'b0;
         state_next.ir_valid    = 1'b0;
         state_next.ir          = `NOP_WORD;
      end else begin
         if (ph.p1) begin
            // RULE_05 latch fetched word into IR
            state_next.ir       = state_reg.fetch_ok ? state_reg.fetch_latch : `NOP_WORD;
            state_next.ir_valid = state_reg.fetch_ok;
            // RULE_03 PC steps in phase one
            // Fetch address keeps the pre-step value, so word N is read, not N+1
            state_next.fetch_pc = state_reg.pc;
            state_next.pc       = state_reg.pc + `PC_STEP;
         end
         if (ph.p4) begin
            // RULE_04 capture word at phase four
            state_next.fetch_latch = prog_data;
            state_next.fetch_ok    = 1'b1;
            // RULE_09 branch costs one extra cycle
            if (state_reg.ir_valid && (branch_taken || irq_enter)) begin
               // RULE_10 drop prefetched word
               state_next.fetch_ok    = 1'b0;
               // RULE_14 interrupt vector
               // Target shows on the fetch address at once; next phase one keeps it there and steps pc past it
               state_next.fetch_pc    = irq_enter ? `IRQ_VECTOR : branch_target;
               state_next.pc          = irq_enter ? `IRQ_VECTOR : branch_target;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Outputs
   // RULE_13 13-bit fetch address; fetch uses pc before its phase-one step
   assign prog_addr      = state_reg.fetch_pc;
   // RULE_08 IR executes while next word is fetched
   assign instr_word     = state_reg.ir;
   assign phase          = ph;
   // RULE_16 flushed slot strobes nothing
   // RULE_06 operand read phase two
   assign exec.operand_read = ph.p2 & state_reg.ir_valid;
   // RULE_07 result write phase four
   assign exec.result_write = ph.p4 & state_reg.ir_valid;
   assign exec.exec_valid   = state_reg.ir_valid;
   assign cycle_clock_out   = state_reg.clk_out;
endmodule // fetch_execute_timing

// ### fetch_execute_timing_monitor.sv
/* Concurrent checks on the fetch/execute sequencer ports.
 Assumes one clock and binding to the top module. */
`include "phase_timing_params.svh"
module fetch_execute_timing_monitor
   import phase_timing_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire logic                    master_clear_n,
   input wire logic                    rc_mode,
   input wire logic [`INSTR_WIDTH-1:0] prog_data,
   input wire logic                    branch_taken,
   input wire logic [`PC_WIDTH-1:0]    branch_target,
   input wire logic                    irq_enter,
   input wire logic [`PC_WIDTH-1:0]    prog_addr,
   input wire logic [`INSTR_WIDTH-1:0] instr_word,
   input wire phase_strobe_t           phase,
   input wire exec_strobe_t            exec,
   input wire logic                    cycle_clock_out
);
   // ==========================================
   // Checks, quiet while either reset holds the core, except AST_HOLD, which is quiet only under sys_rst
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !master_clear_n);
   AST_ONEHOT: assert property ($onehot0(phase)) else $error("phases overlap");
   AST_ORDER: assert property (phase.p1 |=> phase.p2 ##1 phase.p3 ##1 phase.p4 ##1 phase.p1)
      else $error("phase order broken");
   AST_PC_HOLD: assert property ((phase.p3 || phase.p4) |-> $stable(prog_addr))
      else $error("fetch address moved late");
   AST_CAPTURE: assert property (phase.p2 && exec.exec_valid |-> instr_word == $past(prog_data, 2))
      else $error("word not captured at phase four");
   AST_IR_HOLD: assert property ((phase.p3 || phase.p4) |-> $stable(instr_word))
      else $error("instruction word moved");
   AST_READ: assert property (exec.operand_read |-> phase.p2 && exec.exec_valid)
      else $error("operand read out of place");
   AST_WRITE: assert property (exec.result_write |-> phase.p4 && exec.exec_valid)
      else $error("result write out of place");
   AST_OVERLAP: assert property (phase.p2 && exec.exec_valid |-> exec.operand_read ##2 exec.result_write)
      else $error("execute strobes missing");
   AST_FLUSH: assert property (phase.p4 && exec.exec_valid && branch_taken && !irq_enter |=>
      prog_addr == $past(branch_target) ##1 (!exec.exec_valid && instr_word == `NOP_WORD))
      else $error("branch not flushed");
   AST_CLK_OFF: assert property (!$past(rc_mode, 3) |-> !cycle_clock_out)
      else $error("cycle clock outside RC mode");
   AST_HOLD: assert property (disable iff (sys_rst)
      !master_clear_n && !$past(master_clear_n, 1) && !$past(master_clear_n, 2) &&
      !$past(master_clear_n, 3) |-> phase == 4'h0 && prog_addr == `RESET_VECTOR)
      else $error("core not held");
   cover property (phase.p4 && exec.exec_valid && branch_taken);
   cover property (phase.p4 && exec.exec_valid && irq_enter);
   cover property ($rose(cycle_clock_out));
endmodule // fetch_execute_timing_monitor
bind fetch_execute_timing fetch_execute_timing_monitor mon (.clk(clk), .sys_rst(sys_rst),
   .master_clear_n(master_clear_n), .rc_mode(rc_mode), .prog_data(prog_data), .branch_taken(branch_taken),
   .branch_target(branch_target), .irq_enter(irq_enter), .prog_addr(prog_addr), .instr_word(instr_word),
   .phase(phase), .exec(exec), .cycle_clock_out(cycle_clock_out));

// ### phase_gen.sv
/*
 Divide-by-four phase generator: four one-hot enables from osc_in.
 Assumes osc_in is the single system clock and sys_rst is asynchronous.
*/
`include "phase_timing_params.svh"
module phase_gen
   import phase_timing_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          hold,
   output phase_strobe_t      strobe,
   output logic               cycle_clk
);
   typedef struct packed {
      phase_t st;
   } gen_state_t;

   gen_state_t state_reg;
   gen_state_t state_next;

   // ==========================================
   // Phase rotation
   always_comb begin
      state_next = state_reg;
      if (hold) begin
         // RULE_15 hold at phase one
         state_next.st = PH_1;
      end else begin
         // RULE_01 four phases in order
         case (state_reg.st)
            PH_1:    state_next.st = PH_2;
            PH_2:    state_next.st = PH_3;
            PH_3:    state_next.st = PH_4;
            PH_4:    state_next.st = PH_1;
            default: state_next.st = PH_1;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg.st <= PH_1;
      end else begin
         state_reg <= state_next;
      end
   end

   // RULE_02 one cycle is four phases
   assign strobe.p1 = (state_reg.st == PH_1) & ~hold;
   assign strobe.p2 = (state_reg.st == PH_2) & ~hold;
   assign strobe.p3 = (state_reg.st == PH_3) & ~hold;
   assign strobe.p4 = (state_reg.st == PH_4) & ~hold;
   // High in phases one and two, low in three and four
   assign cycle_clk = (state_reg.st == PH_1) | (state_reg.st == PH_2);
endmodule // phase_gen

// ### phase_timing_params.svh
/*
 Timing and layout constants for the four-phase fetch/execute sequencer.
 Assumes inclusion by bare name from the package and the design modules.
*/
// Function
// RULE_01 - The oscillator input is divided by four into four non-overlapping phases that repeat in order.
// RULE_02 - One instruction cycle is exactly four phases, that is four oscillator input periods.
// RULE_03 - The program counter increments once per instruction cycle, in phase one.
// RULE_04 - The instruction word is read from program memory during fetch and captured at phase four.
// RULE_05 - The captured word enters the instruction register at the next phase one and executes in phases two to four.
// RULE_06 - The data memory operand read happens in phase two.
// RULE_07 - The destination result write to data memory happens in phase four.
// RULE_08 - Fetch of the next instruction overlaps execution of the current one, one instruction per cycle.
// RULE_09 - An instruction that changes the program counter takes two instruction cycles.
// RULE_10 - On a branch the prefetched word is discarded and the target is fetched, then executed the cycle after.
// RULE_11 - In RC oscillator mode the oscillator output pin carries a quarter-rate cycle clock.
// RULE_12 - The device holds itself in reset while master clear is low.
// RULE_13 - The program counter is 13 bits, addressing 8K words of 14 bits.
// RULE_14 - After reset the first fetch is from address zero, interrupt entry fetches from address four.
// RULE_15 - During reset the phase generator is held so that the first phase after release is phase one, pipeline empty.
// RULE_16 - The flushed slot after a branch executes as a no-operation.
`ifndef PHASE_TIMING_PARAMS_SVH
`define PHASE_TIMING_PARAMS_SVH
`define PC_WIDTH        13
`define INSTR_WIDTH     14
`define RESET_VECTOR    13'h0000
`define IRQ_VECTOR      13'h0004
`define PC_STEP         13'h0001
`define NOP_WORD        14'h0000
`define ZERO_PHASE_CNT  2'h0
`define LAST_PHASE_CNT  2'h3
`define PHASE_STEP      2'h1
`endif

// ### phase_timing_pkg.sv
/*
 Types shared by the sequencer modules.
 Assumes the params header is on the include path.
*/
`include "phase_timing_params.svh"
package phase_timing_pkg;
   // ==========================================
   // Phase encoding
   typedef enum logic [3:0] {
      PH_1 = 4'h1,
      PH_2 = 4'h2,
      PH_3 = 4'h4,
      PH_4 = 4'h8
   } phase_t;

   // ==========================================
   // Per-phase strobes
   typedef struct packed {
      logic p1;
      logic p2;
      logic p3;
      logic p4;
   } phase_strobe_t;

   // ==========================================
   // Memory access strobes toward the execute datapath
   typedef struct packed {
      logic operand_read;
      logic result_write;
      logic exec_valid;
   } exec_strobe_t;
endpackage

// ### tb.sv
/* Self-checking bench for fetch_execute_timing.
 Assumes the bench acts as program memory and datapath. */
`include "phase_timing_params.svh"
module tb
   import phase_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, sys_rst = 1, master_clear_n = 1, rc_mode = 0, branch_taken = 0, irq_enter = 0;
   logic [13:0] prog_data = 14'h0000, instr_word;
   logic [12:0] branch_target = 13'h0000, prog_addr, a;
   phase_strobe_t phase;
   exec_strobe_t  exec;
   logic          cycle_clock_out;
   int n_mismatch = 0, comparisons = 0, cycles = 0, i, n;
   fetch_execute_timing DUT (.clk(clk), .sys_rst(sys_rst), .master_clear_n(master_clear_n),
      .rc_mode(rc_mode), .prog_data(prog_data), .branch_taken(branch_taken),
      .branch_target(branch_target), .irq_enter(irq_enter), .prog_addr(prog_addr),
      .instr_word(instr_word), .phase(phase), .exec(exec), .cycle_clock_out(cycle_clock_out));
   // ==========================================
   // Clock, memory image and watchdog
   always #5 clk = ~clk;
   // Word tagged with its address, so a stale fetch shows at once
   always @(posedge clk) begin
      #1 prog_data = {1'b1, prog_addr};
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic step(); @(posedge clk); #1; endtask
   task automatic wait_ph(input int k);
      for (i = 0; i < 12 && phase[4-k] !== 1'b1; i++) step();
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic test_seq();
      wait_ph(1); step();
      for (n = 1; phase.p1 !== 1'b1 && n < 9; n++) step();
      chk(n, 4);
      wait_ph(4); a = prog_addr; step(); step();
      chk(instr_word, {1'b1, a});
      chk(exec, 3'h5);
      wait_ph(4); chk(prog_addr, a + `PC_STEP);
      chk(exec, 3'h3);
      $display("test_seq done");
   endtask
   task automatic test_jump(input logic irq);
      wait_ph(4); step(); wait_ph(4);
      branch_taken = 1; irq_enter = irq; branch_target = 13'h1abc;
      step(); branch_taken = 0; irq_enter = 0;
      chk(prog_addr, irq ? `IRQ_VECTOR : 13'h1abc);
      step(); chk(exec.exec_valid, 1'b0);
      chk(instr_word, `NOP_WORD);
      step(); wait_ph(2);
      chk(instr_word, {1'b1, irq ? `IRQ_VECTOR : 13'h1abc});
      $display("test_jump done");
   endtask
   task automatic test_clear();
      master_clear_n = 0;
      repeat (10) step();
      chk(phase, 4'h0);
      master_clear_n = 1; wait_ph(1);
      chk(prog_addr, `RESET_VECTOR);
      chk(exec.exec_valid, 1'b0);
      wait_ph(4); chk(prog_addr, `RESET_VECTOR);
      step(); step(); chk(instr_word, {1'b1, `RESET_VECTOR});
      $display("test_clear done");
   endtask
   task automatic test_clkout();
      n = 0;
      repeat (16) begin step(); n += cycle_clock_out; end
      chk(n, 0);
      rc_mode = 1; repeat (4) step(); n = 0;
      repeat (16) begin step(); n += cycle_clock_out; end
      chk(n, 8);
      $display("test_clkout done");
   endtask
   task automatic print_verdict();
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) step();
      sys_rst = 0;
      test_seq(); test_jump(0); test_jump(1); test_clear(); test_clkout();
      print_verdict();
   end
endmodule // tb
